/* erpc_defs.vh */
// constants for the external reset pin control block
`ifndef ERPC_DEFS_VH
`define ERPC_DEFS_VH
// least low time on the reset pin that always resets, in clocks
`define ERPC_PIN_MIN_CYC      3'h4
// default reset delay held after an internal reset source goes away or from when the pin is confirmed low, in clocks
`define ERPC_RST_DELAY_CYC    16'h0040
// width of the reset delay counter
`define ERPC_DELAY_W          16
// reset cause vector bit positions
`define ERPC_CAUSE_POR        0
`define ERPC_CAUSE_PIN        1
`define ERPC_CAUSE_WDT        2
`define ERPC_CAUSE_STOP       3
`define ERPC_CAUSE_BOD        4
`define ERPC_CAUSE_W          5
// reset values of the cause flags
`define ERPC_CAUSE_RST        5'h01
`endif

/* erpc_pin_filter.v */
// glitch filter that confirms the reset pin low for a set number of clocks
`timescale 1ns/1ps
`default_nettype none
`include "erpc_defs.vh"
module erpc_pin_filter #(
  parameter [2:0] MIN_CYC = `ERPC_PIN_MIN_CYC
) (
  input  wire clk,
  input  wire rst,
  input  wire pinLowSync,
  output reg  pinAsserted_ff
);
  reg  [2:0] lowCnt_ff;
  reg  [2:0] nxt_lowCnt;
  // count consecutive sampled low clocks
  always @* begin
    if (!pinLowSync)
      nxt_lowCnt = 3'h0;
    else if (lowCnt_ff != MIN_CYC)
      nxt_lowCnt = lowCnt_ff + 3'h1;
    else
      nxt_lowCnt = lowCnt_ff;
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lowCnt_ff      <= 3'h0;
      pinAsserted_ff <= 1'b0;
    end else begin
      lowCnt_ff      <= nxt_lowCnt;
      pinAsserted_ff <= (nxt_lowCnt == MIN_CYC);
    end
  end
endmodule // erpc_pin_filter
`default_nettype wire

/* erpc_reset_ctrl.v */
// reset sequencer for the external reset pin, debug unit and cause flags
// Summary of operation
// - system reset from pin, power-on, watchdog, stop exit or brown-out
// - pin low four clocks always resets; driver must hold four
// - device stays in reset while pin input held low
// - leaves reset on third clock edge after pin release past timeout
// - pin reset sets pin_reset_flag in watchdog control register
// - pin is open-drain low indicator during reset until the delay ends, or when port enables
// - internal resets also signalled on the pin
// - internal event drives pin low until its reset delay elapses
// - debug unit request resets chip but not debug unit
// - debug reset request bit clears itself during the reset
// - debug-started reset sets power-on flag in reset cause register
// - ports A, B, C default to input, alternates off, on reset
`timescale 1ns/1ps
`default_nettype none
`include "erpc_defs.vh"
module erpc_reset_ctrl #(
  parameter [`ERPC_DELAY_W-1:0] RST_DELAY_CYC = `ERPC_RST_DELAY_CYC,
  parameter                     PORT_W        = 8
) (
  input  wire              clk,
  input  wire              rst,
  input  wire              resetPinIn,
  output reg               resetPinOut_ff,
  output reg               resetPinOe_ff,
  input  wire              porEvent,
  input  wire              wdtTimeout,
  input  wire              stopExit,
  input  wire              bodWarning,
  input  wire              portIndicatorEn,
  input  wire              dbgResetSet,
  output reg               dbgResetReq_ff,
  input  wire              causeClear,
  output reg               sysReset_ff,
  output reg               pinResetFlag_ff,
  output reg  [4:0]        causeFlags_ff,
  output reg  [PORT_W-1:0] portADir_ff,
  output reg  [PORT_W-1:0] portBDir_ff,
  output reg  [PORT_W-1:0] portCDir_ff,
  output reg  [PORT_W-1:0] portAAlt_ff,
  output reg  [PORT_W-1:0] portBAlt_ff,
  output reg  [PORT_W-1:0] portCAlt_ff
);
  localparam [3:0] ST_RUN   = 4'h1;
  localparam [3:0] ST_HOLD  = 4'h2;
  localparam [3:0] ST_DELAY = 4'h4;
  localparam [3:0] ST_WAIT  = 4'h8;

  reg                     pinMeta_ff;
  reg                     pinLowSync_ff;
  reg                     oeDly1_ff;
  reg                     oeDly2_ff;
  reg                     pinExtLow;
  wire                    pinAsserted;
  reg  [3:0]              state_ff;
  reg  [3:0]              nxt_state;
  reg  [`ERPC_DELAY_W-1:0] delayCnt_ff;
  reg  [`ERPC_DELAY_W-1:0] nxt_delayCnt;
  reg                     internalEvt;
  reg                     anySource;
  reg                     dbgPending_ff;

  // states in which the device pulls the pin low itself
  function drivesPin;
    input [3:0] st;
    begin
      drivesPin = (st == ST_HOLD) | (st == ST_DELAY);
    end
  endfunction

  // two-stage synchroniser on the pin, stored inverted
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta_ff    <= 1'b0;
      pinLowSync_ff <= 1'b0;
      oeDly1_ff     <= 1'b1;
      oeDly2_ff     <= 1'b1;
    end else begin
      pinMeta_ff    <= ~resetPinIn;
      pinLowSync_ff <= pinMeta_ff;
      // own drive delayed to line up with the synchroniser
      oeDly1_ff     <= resetPinOe_ff;
      oeDly2_ff     <= oeDly1_ff;
    end
  end

  erpc_pin_filter #(
    .MIN_CYC (`ERPC_PIN_MIN_CYC)
  ) u_filter (
    .clk            (clk),
    .rst            (rst),
    .pinLowSync     (pinExtLow),
    .pinAsserted_ff (pinAsserted)
  );

  always @* begin
    internalEvt = porEvent | wdtTimeout | stopExit | bodWarning | dbgResetReq_ff;
    anySource   = internalEvt | pinAsserted;
    // own pull-down must not latch the device in reset
    pinExtLow   = pinLowSync_ff & ~oeDly2_ff;
  end

  // sequencer: hold while an internal source stays, then count the delay
  always @* begin
    nxt_state    = state_ff;
    nxt_delayCnt = delayCnt_ff;
    case (state_ff)
      ST_RUN: begin
        if (internalEvt) begin
          nxt_state    = ST_HOLD;
          nxt_delayCnt = RST_DELAY_CYC;
        end else if (pinAsserted) begin
          nxt_state    = ST_DELAY;
          nxt_delayCnt = RST_DELAY_CYC;
        end
      end
      // internal source still present
      ST_HOLD: begin
        nxt_delayCnt = RST_DELAY_CYC;
        if (!internalEvt)
          nxt_state = ST_DELAY;
      end
      // pull the pin for the reset delay
      ST_DELAY: begin
        if (internalEvt) begin
          nxt_state    = ST_HOLD;
          nxt_delayCnt = RST_DELAY_CYC;
        end else if (delayCnt_ff <= 16'h0001) begin
          nxt_state = ST_WAIT;
        end else begin
          nxt_delayCnt = delayCnt_ff - 16'h0001;
        end
      end
      // pin released by us, stay until it reads high
      ST_WAIT: begin
        if (internalEvt) begin
          nxt_state    = ST_HOLD;
          nxt_delayCnt = RST_DELAY_CYC;
        end else if (!oeDly2_ff && !pinLowSync_ff) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state    = ST_HOLD;
        nxt_delayCnt = RST_DELAY_CYC;
      end
    endcase
  end

  // state, reset output and pin indicator
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff       <= ST_HOLD;
      delayCnt_ff    <= `ERPC_RST_DELAY_CYC;
      sysReset_ff    <= 1'b1;
      resetPinOut_ff <= 1'b0;
      resetPinOe_ff  <= 1'b1;
    end else begin
      state_ff    <= nxt_state;
      delayCnt_ff <= nxt_delayCnt;
      sysReset_ff <= (nxt_state != ST_RUN);
      resetPinOut_ff <= 1'b0;
      // indicator while holding or counting the reset delay, or port enable
      resetPinOe_ff <= drivesPin(nxt_state) | internalEvt | portIndicatorEn;
    end
  end

  // debug unit request, kept out of the system reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dbgResetReq_ff <= 1'b0;
      dbgPending_ff  <= 1'b0;
    end else begin
      // set request; clear once reset entered
      if (dbgResetSet)
        dbgResetReq_ff <= 1'b1;
      else if (sysReset_ff && dbgResetReq_ff)
        dbgResetReq_ff <= 1'b0;
      if (dbgResetReq_ff && sysReset_ff)
        dbgPending_ff <= 1'b1;
      else if (!sysReset_ff)
        dbgPending_ff <= 1'b0;
    end
  end

  // cause flags, set wins over clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      causeFlags_ff   <= `ERPC_CAUSE_RST;
      pinResetFlag_ff <= 1'b0;
    end else begin
      if (pinAsserted)
        pinResetFlag_ff <= 1'b1;
      else if (causeClear)
        pinResetFlag_ff <= 1'b0;
      causeFlags_ff <= (causeClear ? 5'h00 : causeFlags_ff)
                     | {bodWarning, stopExit, wdtTimeout, pinAsserted,
                        porEvent | dbgPending_ff};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      portADir_ff <= {PORT_W{1'b0}};
      portBDir_ff <= {PORT_W{1'b0}};
      portCDir_ff <= {PORT_W{1'b0}};
      portAAlt_ff <= {PORT_W{1'b0}};
      portBAlt_ff <= {PORT_W{1'b0}};
      portCAlt_ff <= {PORT_W{1'b0}};
    end else if (sysReset_ff) begin
      portADir_ff <= {PORT_W{1'b0}};
      portBDir_ff <= {PORT_W{1'b0}};
      portCDir_ff <= {PORT_W{1'b0}};
      portAAlt_ff <= {PORT_W{1'b0}};
      portBAlt_ff <= {PORT_W{1'b0}};
      portCAlt_ff <= {PORT_W{1'b0}};
    end
  end
endmodule // erpc_reset_ctrl
`default_nettype wire

/* erpc_board.sv */
// board side of the shared reset line
`timescale 1ns/1ps
`default_nettype none
module erpc_board (
  input  wire logic extLow,
  input  wire logic oe,
  output wire logic pin
);
  assign pin = !(extLow || oe);
endmodule // erpc_board
`default_nettype wire

/* erpc_monitor.sv */
// reset sequencer checker
`timescale 1ns/1ps
`default_nettype none
module erpc_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic resetPinIn,
  input wire logic resetPinOe_ff,
  input wire logic wdtTimeout,
  input wire logic dbgResetSet,
  input wire logic dbgResetReq_ff,
  input wire logic sysReset_ff,
  input wire logic pinResetFlag_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_src; wdtTimeout |=> sysReset_ff && resetPinOe_ff; endproperty
  a_src: assert property (p_src) else $error("src");
  property p_hold; !resetPinIn [*8] |-> sysReset_ff; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_flag; (!resetPinIn && !resetPinOe_ff) ##1 !resetPinIn [*7] |-> pinResetFlag_ff; endproperty
  a_flag: assert property (p_flag) else $error("flag");
  property p_exit; !resetPinIn [*8] ##1 resetPinIn |-> ##[1:3] !sysReset_ff; endproperty
  a_exit: assert property (p_exit) else $error("exit");
  property p_dreq; dbgResetSet |=> dbgResetReq_ff ##1 sysReset_ff; endproperty
  a_dreq: assert property (p_dreq) else $error("dbg");
  property p_dclr; dbgResetReq_ff && sysReset_ff |=> !dbgResetReq_ff; endproperty
  a_dclr: assert property (p_dclr) else $error("req");
  property p_oe; $rose(sysReset_ff) |-> resetPinOe_ff [*4]; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_rls; $fell(sysReset_ff) |-> !resetPinOe_ff; endproperty
  a_rls: assert property (p_rls) else $error("rls");
  c_dbg: cover property (dbgResetReq_ff && sysReset_ff);
  c_exit: cover property (!resetPinIn [*8] ##1 resetPinIn);
  c_flag: cover property ($rose(pinResetFlag_ff));
endmodule // erpc_monitor
bind erpc_reset_ctrl erpc_monitor mon (.*);
`default_nettype wire

/* erpc_reset_ctrl_test.sv */
// bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module erpc_reset_ctrl_test;
  logic       clk = 0, rst = 1;
  logic [6:0] drv = 0;
  wire        pin, oe, req, sys, flg;
  wire  [4:0] cse;
  wire [47:0] prt;
  int         mismatches = 0, n_tests = 0, cyc = 0;
  erpc_board board (.extLow(drv[4]), .oe(oe), .pin(pin));
  erpc_reset_ctrl #(.RST_DELAY_CYC(16'h0008)) uut (.clk(clk), .rst(rst), .resetPinIn(pin), .resetPinOut_ff(),
    .resetPinOe_ff(oe), .porEvent(drv[0]), .wdtTimeout(drv[1]), .stopExit(drv[2]), .bodWarning(drv[3]),
    .portIndicatorEn(1'b0), .dbgResetSet(drv[6]), .dbgResetReq_ff(req), .causeClear(drv[5]), .sysReset_ff(sys),
    .pinResetFlag_ff(flg), .causeFlags_ff(cse), .portADir_ff(prt[7:0]), .portBDir_ff(prt[15:8]),
    .portCDir_ff(prt[23:16]), .portAAlt_ff(prt[31:24]), .portBAlt_ff(prt[39:32]), .portCAlt_ff(prt[47:40]));
  // clock and hang limit
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) end_sim();
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pls(input logic [6:0] m, input int n);
    drv = m;
    tk(n);
    drv = 0;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_tests++;
    mismatches += (got !== exp);
    if (got !== exp) $display("MISMATCH %s exp %h got %h", nm, exp, got);
  endtask
  task automatic idle;
    for (int i = 0; i < 40 && sys !== 1'b0; i++) tk(1);
  endtask
  task automatic end_sim;
    mismatches += (cyc >= 3000);
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // sources, pin pulses, debug request
  initial begin
    tk(5);
    rst = 0;
    chk("dflt", 8'h01, {|prt, cse});
    for (int i = 0; i < 4; i++) begin
      pls(7'h01 << i, 1);
      chk("src", 8'h07, {sys, !pin, cse[i + (i > 0)]});
      tk(8);
      chk("delay", 8'h01, oe);
      idle();
    end
    pls(7'h10, 3);
    tk(8);
    chk("short", 8'h00, sys);
    pls(7'h10, 4);
    tk(4);
    chk("pin", 8'h07, {sys, flg, cse[1]});
    idle();
    pls(7'h10, 20);
    chk("hold", 8'h01, sys);
    tk(4);
    chk("exit", 8'h00, sys);
    pls(7'h20, 1);
    chk("clear", 8'h00, {flg, cse});
    pls(7'h40, 1);
    chk("req", 8'h01, req);
    tk(3);
    chk("reqclr", 8'h01, {req, cse[0]});
    idle();
    end_sim();
  end
endmodule // erpc_reset_ctrl_test
`default_nettype wire
